// ===== hw/clock_buffer_cfg.svh
// constants for the global clock buffer and multiplexer array
//
// Contract
// - With select at 0 the multiplexer output follows the primary input, with select at 1 the alternate input.
// - Every high phase of the output is a whole high phase of the input in use; a low phase at a switch can be as short as two sampling cycles.
// - The two inputs of one multiplexer are unrelated clocks that may be fully asynchronous to each other.
// - In buffer form the element forwards the primary input alone and ignores select.
// - In gated form an enable passes or blocks the primary clock through the same glitch-free switching.
// - Multiplexers come in pairs with crossed inputs, one's primary input being its partner's alternate input.
// - The first matrix input is the primary path of a buffer and the second is its alternate source.
// - A left or right edge pair draws each input from the half-clock pin, a routing line or a clock manager.
// - A top or bottom edge pair picks each input from two global pins, two clock managers or one routing line.
// - Each top or bottom pair reaches four of the eight global pins of its edge so differential inputs cost no buffer.
// - Each left or right edge pair is fed by only two dedicated half-clock pins.
// - There are 24 multiplexers; top and bottom ones reach all quadrants, left and right ones only their half.
`ifndef CLOCK_BUFFER_CFG_SVH
`define CLOCK_BUFFER_CFG_SVH

`define CB_NUM_MUX 24
`define CB_NUM_PAIR 12
`define CB_TB_PAIRS 4
`define CB_LR_PAIRS 4
`define CB_EDGE_MUX 8
`define CB_SRC_W 3
`define CB_MODE_W 2
`define CB_GPIN_NUM 16
`define CB_HPIN_NUM 8

// global pin bases of each top/bottom pair: low group and high group
`define CB_TB_LO0 6
`define CB_TB_HI0 10
`define CB_TB_LO1 4
`define CB_TB_HI1 8
`define CB_TB_LO2 2
`define CB_TB_HI2 14
`define CB_TB_LO3 0
`define CB_TB_HI3 12

// half-clock pin base of each left and right pair
`define CB_LH_BASE0 6
`define CB_LH_BASE1 4
`define CB_LH_BASE2 2
`define CB_LH_BASE3 0
`define CB_RH_BASE0 2
`define CB_RH_BASE1 0
`define CB_RH_BASE2 6
`define CB_RH_BASE3 4

`endif

// ===== hw/clock_buffer_pkg.sv
// types for the global clock buffer and multiplexer array
package clock_buffer_pkg;

  // matrix source codes; left/right edges know pin_lo, cm_a and route only
  typedef enum logic [2:0] {
    SRC_PIN_LO = 3'h0,
    SRC_PIN_HI = 3'h1,
    SRC_CM_A = 3'h2,
    SRC_CM_B = 3'h3,
    SRC_ROUTE = 3'h4
  } src_code_t;

  // element form
  typedef enum logic [1:0] {
    MODE_MUX = 2'h0,
    MODE_BUFFER = 2'h1,
    MODE_GATED = 2'h2
  } drv_mode_t;

  // which clock feeds the output
  typedef enum logic [1:0] {
    PICK_PRIMARY = 2'h0,
    PICK_ALTERNATE = 2'h1,
    PICK_OFF = 2'h2
  } pick_t;

  // switching state
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_DRAIN = 2'h1,
    ST_ARM = 2'h2
  } sel_state_t;

endpackage : clock_buffer_pkg

// ===== hw/clk_sel_if.sv
// bundle between the switch matrix and one glitch-free selector
`timescale 1ns/1ps
interface clk_sel_if;
  import clock_buffer_pkg::*;
  logic primary;
  logic alternate;
  logic select;
  logic enable;
  drv_mode_t mode;
  logic clk_out;
  logic switching;
  pick_t active;

  modport ctrl (
    output primary, alternate, select, enable, mode,
    input clk_out, switching, active
  );
  modport sel (
    input primary, alternate, select, enable, mode,
    output clk_out, switching, active
  );
endinterface : clk_sel_if

// ===== hw/glitchless_clock_selector.sv
// one glitch-free clock selector, sampled on the system clock
`timescale 1ns/1ps
module glitchless_clock_selector
  import clock_buffer_pkg::*;
(
  input wire logic sys_clk_i, // sampling clock
  input wire logic rst_n_i, // async reset, active low
  clk_sel_if.sel port_if // clock candidates and output
);

  sel_state_t state_reg;
  pick_t cur_reg;
  pick_t target;
  logic out_reg;

  // level of a candidate clock
  function automatic logic level_of(input pick_t p, input logic prim, input logic alt);
    logic lv;
    lv = 1'b0;
    unique case (p)
      PICK_PRIMARY: lv = prim;
      PICK_ALTERNATE: lv = alt;
      default: lv = 1'b0;
    endcase
    return lv;
  endfunction : level_of

  // requested source from form, select and enable
  always_comb begin
    unique case (port_if.mode)
      MODE_BUFFER: target = PICK_PRIMARY;
      MODE_GATED: target = port_if.enable ? PICK_PRIMARY : PICK_OFF;
      MODE_MUX: target = port_if.select ? PICK_ALTERNATE : PICK_PRIMARY;
      default: target = port_if.select ? PICK_ALTERNATE : PICK_PRIMARY;
    endcase
  end

  // switching sequence: drain old high, park low, arm on new low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_ARM;
      cur_reg <= PICK_PRIMARY;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (target != cur_reg) begin
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!level_of(cur_reg, port_if.primary, port_if.alternate)) begin
            cur_reg <= target;
            state_reg <= ST_ARM;
          end
        end
        ST_ARM: begin
          cur_reg <= target;
          if (!level_of(target, port_if.primary, port_if.alternate)) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_ARM;
      endcase
    end
  end

  // output clock; never starts mid high phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_reg <= 1'b0;
    end else if (state_reg == ST_RUN) begin
      out_reg <= level_of(cur_reg, port_if.primary, port_if.alternate);
    end else if (state_reg == ST_DRAIN) begin
      out_reg <= out_reg & level_of(cur_reg, port_if.primary, port_if.alternate);
    end else begin
      out_reg <= 1'b0;
    end
  end

  assign port_if.clk_out = out_reg;
  assign port_if.switching = (state_reg != ST_RUN);
  assign port_if.active = cur_reg;

endmodule : glitchless_clock_selector

// ===== hw/clock_buffer_array.sv
// array of 24 global clock selectors with edge switch matrices
`timescale 1ns/1ps
`include "clock_buffer_cfg.svh"
module clock_buffer_array
  import clock_buffer_pkg::*;
#(
  parameter logic LR_CM_PRESENT = 1'b1 // left/right clock managers fitted
)(
  input wire logic sys_clk_i, // 200 MHz sampling clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [`CB_GPIN_NUM-1:0] global_clock_pin_i, // top/bottom pins
  input wire logic [`CB_HPIN_NUM-1:0] left_half_clock_pin_i, // left pins
  input wire logic [`CB_HPIN_NUM-1:0] right_half_clock_pin_i, // right pins
  input wire logic [`CB_NUM_MUX-1:0] clock_manager_i, // manager outputs
  input wire logic [`CB_NUM_MUX-1:0] routing_line_i, // general routing
  input wire logic [`CB_NUM_MUX*`CB_SRC_W-1:0] src_sel_i, // matrix codes
  input wire logic [`CB_NUM_MUX-1:0] select_i, // per-mux select
  input wire logic [`CB_NUM_MUX-1:0] enable_i, // per-mux gate enable
  input wire logic [`CB_NUM_MUX*`CB_MODE_W-1:0] mode_i, // per-mux form
  output logic [`CB_EDGE_MUX-1:0] global_line_o, // to all quadrants
  output logic [`CB_EDGE_MUX-1:0] left_half_line_o, // left quadrants
  output logic [`CB_EDGE_MUX-1:0] right_half_line_o, // right quadrants
  output logic [`CB_NUM_MUX-1:0] switching_o, // change in progress
  output logic [`CB_NUM_MUX-1:0] active_alt_o // alternate is live
);

  ////////////////////////////////////////////////////////////////////////////
  // pin maps

  // low global pin group of a top/bottom pair
  function automatic int tb_lo(input int p);
    int b;
    b = `CB_TB_LO3;
    unique case (p)
      0: b = `CB_TB_LO0;
      1: b = `CB_TB_LO1;
      2: b = `CB_TB_LO2;
      default: b = `CB_TB_LO3;
    endcase
    return b;
  endfunction : tb_lo

  // high global pin group of a top/bottom pair
  function automatic int tb_hi(input int p);
    int b;
    b = `CB_TB_HI3;
    unique case (p)
      0: b = `CB_TB_HI0;
      1: b = `CB_TB_HI1;
      2: b = `CB_TB_HI2;
      default: b = `CB_TB_HI3;
    endcase
    return b;
  endfunction : tb_hi

  // half-clock pin base of a left pair
  function automatic int lh_base(input int q);
    int b;
    b = `CB_LH_BASE3;
    unique case (q)
      0: b = `CB_LH_BASE0;
      1: b = `CB_LH_BASE1;
      2: b = `CB_LH_BASE2;
      default: b = `CB_LH_BASE3;
    endcase
    return b;
  endfunction : lh_base

  // half-clock pin base of a right pair
  function automatic int rh_base(input int q);
    int b;
    b = `CB_RH_BASE3;
    unique case (q)
      0: b = `CB_RH_BASE0;
      1: b = `CB_RH_BASE1;
      2: b = `CB_RH_BASE2;
      default: b = `CB_RH_BASE3;
    endcase
    return b;
  endfunction : rh_base

  ////////////////////////////////////////////////////////////////////////////
  // matrix source pickers

  // five-way pick on the top and bottom edges
  function automatic logic pick5(input logic [`CB_SRC_W-1:0] code, input logic pin_lo,
                                 input logic pin_hi, input logic cm_a, input logic cm_b,
                                 input logic route);
    logic v;
    v = 1'b0;
    unique case (src_code_t'(code))
      SRC_PIN_LO: v = pin_lo;
      SRC_PIN_HI: v = pin_hi;
      SRC_CM_A: v = cm_a;
      SRC_CM_B: v = cm_b;
      SRC_ROUTE: v = route;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pick5

  // three-way pick on the left and right edges
  function automatic logic pick3(input logic [`CB_SRC_W-1:0] code, input logic pin,
                                 input logic cm, input logic route);
    logic v;
    v = 1'b0;
    unique case (src_code_t'(code))
      SRC_PIN_LO: v = pin;
      SRC_CM_A: v = cm;
      SRC_ROUTE: v = route;
      default: v = 1'b0; // pin_hi and cm_b do not exist here
    endcase
    return v;
  endfunction : pick3

  ////////////////////////////////////////////////////////////////////////////
  // switch matrix outputs, two per pair

  logic [`CB_NUM_MUX-1:0] matrix_line;
  logic [`CB_NUM_MUX-1:0] mux_out;

  genvar gp;
  genvar gk;
  generate
    // top and bottom pairs: four of the edge's eight global pins each
    for (gp = 0; gp < `CB_TB_PAIRS; gp++) begin : g_tb
      for (gk = 0; gk < 2; gk++) begin : g_in
        localparam int LO_PIN = tb_lo(gp) + 1 - gk;
        localparam int HI_PIN = tb_hi(gp) + 1 - gk;
        // candidate set: two pins, both pair managers, one routing line
        assign matrix_line[2*gp+gk] = pick5(src_sel_i[(2*gp+gk)*`CB_SRC_W +: `CB_SRC_W],
                                            global_clock_pin_i[LO_PIN],
                                            global_clock_pin_i[HI_PIN],
                                            clock_manager_i[2*gp],
                                            clock_manager_i[2*gp+1],
                                            routing_line_i[2*gp+gk]);
      end
    end

    // left pairs: two dedicated half-clock pins per pair
    for (gp = 0; gp < `CB_LR_PAIRS; gp++) begin : g_left
      for (gk = 0; gk < 2; gk++) begin : g_in
        localparam int SLOT = 2*(`CB_TB_PAIRS+gp) + gk;
        localparam int PIN = lh_base(gp) + 1 - gk;
        // pin, routing line, or manager where fitted
        assign matrix_line[SLOT] = pick3(src_sel_i[SLOT*`CB_SRC_W +: `CB_SRC_W],
                                         left_half_clock_pin_i[PIN],
                                         clock_manager_i[SLOT] & LR_CM_PRESENT,
                                         routing_line_i[SLOT]);
      end
    end

    // right pairs: same structure, own pin order
    for (gp = 0; gp < `CB_LR_PAIRS; gp++) begin : g_right
      for (gk = 0; gk < 2; gk++) begin : g_in
        localparam int SLOT = 2*(`CB_TB_PAIRS+`CB_LR_PAIRS+gp) + gk;
        localparam int PIN = rh_base(gp) + 1 - gk;
        // pin, routing line, or manager where fitted
        assign matrix_line[SLOT] = pick3(src_sel_i[SLOT*`CB_SRC_W +: `CB_SRC_W],
                                         right_half_clock_pin_i[PIN],
                                         clock_manager_i[SLOT] & LR_CM_PRESENT,
                                         routing_line_i[SLOT]);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // selectors, crossed in pairs

  genvar gm;
  generate
    for (gm = 0; gm < `CB_NUM_MUX; gm++) begin : g_mux
      localparam int MATE = gm ^ 1;
      clk_sel_if sel_bus ();

      // own matrix line is primary, partner's line is alternate
      assign sel_bus.primary = matrix_line[gm];
      assign sel_bus.alternate = matrix_line[MATE];
      assign sel_bus.select = select_i[gm];
      assign sel_bus.enable = enable_i[gm];
      assign sel_bus.mode = drv_mode_t'(mode_i[gm*`CB_MODE_W +: `CB_MODE_W]);

      glitchless_clock_selector u_sel (
        .sys_clk_i (sys_clk_i),
        .rst_n_i (rst_n_i),
        .port_if (sel_bus.sel)
      );

      // status taps
      assign mux_out[gm] = sel_bus.clk_out;
      assign switching_o[gm] = sel_bus.switching;
      assign active_alt_o[gm] = (sel_bus.active == PICK_ALTERNATE);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // spine distribution

  // top/bottom reach every quadrant, edges only their half
  assign global_line_o = mux_out[`CB_EDGE_MUX-1:0];
  assign left_half_line_o = mux_out[2*`CB_EDGE_MUX-1:`CB_EDGE_MUX];
  assign right_half_line_o = mux_out[3*`CB_EDGE_MUX-1:2*`CB_EDGE_MUX];

endmodule : clock_buffer_array

// ===== verif/clock_sources.sv
// partner model: free-running candidate clocks for every matrix input
`timescale 1ns/1ps
module clock_sources (
  input wire logic sys_clk_i, // bench clock
  output logic [79:0] src_o // pins, managers, routing lines
);
  int cnt [80]; // half-period counters

  // staggered start phases, then each line toggles at its own rate
  initial begin
    for (int i = 0; i < 80; i++) begin
      cnt[i] = i % 3;
      src_o[i] = i[0];
    end
    forever begin
      @(negedge sys_clk_i);
      for (int i = 0; i < 80; i++) begin
        cnt[i] = cnt[i] + 1;
        if (cnt[i] >= 2 + i % 4) begin
          cnt[i] = 0;
          src_o[i] = ~src_o[i];
        end
      end
    end
  end
endmodule : clock_sources

// ===== verif/clock_buffer_array_assertions.sv
// concurrent checks on the clock buffer array ports
`timescale 1ns/1ps
`include "clock_buffer_cfg.svh"
module clock_buffer_array_checker
  import clock_buffer_pkg::*;
(
  input wire logic sys_clk_i, // sampling clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [`CB_NUM_MUX-1:0] select_i, // per-mux select
  input wire logic [`CB_NUM_MUX-1:0] enable_i, // gate enables
  input wire logic [`CB_NUM_MUX*`CB_MODE_W-1:0] mode_i, // element forms
  input wire logic [`CB_EDGE_MUX-1:0] global_line_o, // mux 0..7
  input wire logic [`CB_EDGE_MUX-1:0] left_half_line_o, // mux 8..15
  input wire logic [`CB_EDGE_MUX-1:0] right_half_line_o, // mux 16..23
  input wire logic [`CB_NUM_MUX-1:0] switching_o, // change in progress
  input wire logic [`CB_NUM_MUX-1:0] active_alt_o // alternate live
);
  logic [`CB_NUM_MUX-1:0] line; // lines in mux order
  assign line = {right_half_line_o, left_half_line_o, global_line_o};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // lines parked low while the first source is awaited
  a_reset_park_low: assert property ($rose(rst_n_i) |-> line == '0 && &switching_o)
    else $error("lines not parked after reset");

  // per-mux relations
  for (genvar m = 0; m < `CB_NUM_MUX; m++) begin : g_mux
    logic is_buf;
    logic is_gate;
    assign is_buf = mode_i[2*m +: 2] == MODE_BUFFER;
    assign is_gate = mode_i[2*m +: 2] == MODE_GATED;
    sequence s_buf_run;
      is_buf && !switching_o[m];
    endsequence
    sequence s_gate_off;
      (is_gate && !enable_i[m]) [*8];
    endsequence
    sequence s_alt_run;
      (!switching_o[m] && !is_buf && !is_gate && select_i[m]) [*3];
    endsequence
    a_rise_from_run: assert property ($rose(line[m]) |-> !$past(switching_o[m]))
      else $error("line rose during a switch");
    a_high_min_two: assert property ($rose(line[m]) |=> line[m])
      else $error("one-sample high phase");
    a_low_min_two: assert property ($fell(line[m]) |=> !line[m])
      else $error("one-sample low phase");
    a_switch_bounded: assert property ($rose(switching_o[m]) |-> ##[1:40] !switching_o[m])
      else $error("switch did not complete");
    a_buffer_primary: assert property (s_buf_run [*2] |-> !active_alt_o[m])
      else $error("buffer form took alternate");
    a_gate_blocks: assert property (s_gate_off |-> ##2 !line[m])
      else $error("gate did not block clock");
    a_alt_tracks_sel: assert property (s_alt_run |-> active_alt_o[m])
      else $error("select 1 without alternate");
  end
endmodule : clock_buffer_array_checker

bind clock_buffer_array clock_buffer_array_checker u_chk (.sys_clk_i, .rst_n_i, .select_i,
  .enable_i, .mode_i, .global_line_o, .left_half_line_o, .right_half_line_o, .switching_o,
  .active_alt_o);

// ===== verif/tb.sv
// self-checking bench for the clock buffer array
`timescale 1ns/1ps
`include "clock_buffer_cfg.svh"
module tb
  import clock_buffer_pkg::*;
;
  logic sys_clk_i;
  logic rst_n_i;
  logic [`CB_NUM_MUX*`CB_SRC_W-1:0] src_sel;
  logic [`CB_NUM_MUX-1:0] sel;
  logic [`CB_NUM_MUX-1:0] ena;
  logic [`CB_NUM_MUX*`CB_MODE_W-1:0] mode;
  logic [79:0] src;
  logic [7:0] gl, ll, rl;
  logic [23:0] sw, alt, all_out;
  int errors;
  int cmp_count;
  int cycles;
  assign all_out = {rl, ll, gl};

  clock_sources partner (.sys_clk_i(sys_clk_i), .src_o(src));
  clock_buffer_array uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .global_clock_pin_i(src[15:0]), .left_half_clock_pin_i(src[23:16]),
    .right_half_clock_pin_i(src[31:24]), .clock_manager_i(src[55:32]),
    .routing_line_i(src[79:56]), .src_sel_i(src_sel), .select_i(sel), .enable_i(ena),
    .mode_i(mode), .global_line_o(gl), .left_half_line_o(ll), .right_half_line_o(rl),
    .switching_o(sw), .active_alt_o(alt));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  task summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task cmp(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : cmp

  // reset with checks on the parked outputs
  task do_reset();
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    cmp(|all_out, 1'b0, "line high in reset");
    cmp(&sw, 1'b1, "not parked in reset");
    rst_n_i = 1'b1;
  endtask : do_reset

  // wait for lane l to settle
  task settle(input int l);
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 60 && sw[l] !== 1'b0; i++) @(posedge sys_clk_i);
    #1;
    cmp(sw[l], 1'b0, "switch never finished");
  endtask : settle

  // lane l repeats source s one edge later
  task follow(input int l, input int s);
    logic v;
    settle(l);
    repeat (12) begin
      @(posedge sys_clk_i);
      v = src[s];
      #1;
      cmp(all_out[l], v, "line not following source");
    end
  endtask : follow

  task t_switch();
    @(negedge sys_clk_i);
    sel[0] = 1'b1;
    follow(0, 57);
    cmp(alt[0], 1'b1, "alternate not live");
    @(negedge sys_clk_i);
    sel[0] = 1'b0;
    @(negedge sys_clk_i);
    sel[0] = 1'b1;
    @(negedge sys_clk_i);
    sel[0] = 1'b0;
    follow(0, 56);
    cmp(alt[0], 1'b0, "primary not live");
  endtask : t_switch

  task t_cross();
    follow(1, 57);
    @(negedge sys_clk_i);
    sel[1] = 1'b1;
    follow(1, 56);
    @(negedge sys_clk_i);
    sel[1] = 1'b0;
  endtask : t_cross

  task t_buffer();
    @(negedge sys_clk_i);
    mode[1:0] = MODE_BUFFER;
    sel[0] = 1'b1;
    follow(0, 56);
    cmp(alt[0], 1'b0, "buffer took alternate");
    @(negedge sys_clk_i);
    mode[1:0] = MODE_MUX;
    sel[0] = 1'b0;
  endtask : t_buffer

  task t_gated();
    @(negedge sys_clk_i);
    mode[1:0] = MODE_GATED;
    ena[0] = 1'b0;
    settle(0);
    repeat (10) begin
      @(posedge sys_clk_i);
      #1;
      cmp(gl[0], 1'b0, "gated line not blocked");
    end
    @(negedge sys_clk_i);
    ena[0] = 1'b1;
    follow(0, 56);
    @(negedge sys_clk_i);
    mode[1:0] = MODE_MUX;
  endtask : t_gated

  // unused form code 3 behaves as a plain multiplexer
  task t_mode3();
    @(negedge sys_clk_i);
    mode[1:0] = 2'h3;
    sel[0] = 1'b1;
    follow(0, 57);
    cmp(alt[0], 1'b1, "form 3 not a mux");
    @(negedge sys_clk_i);
    mode[1:0] = MODE_MUX;
    sel[0] = 1'b0;
  endtask : t_mode3

  // matrix codes against pins, managers and routing lines
  task t_pin_map();
    automatic int slot [11] = '{0, 0, 0, 0, 1, 1, 8, 9, 8, 16, 16};
    automatic int code [11] = '{0, 1, 2, 3, 0, 1, 0, 0, 2, 0, 4};
    automatic int pin [11] = '{7, 11, 32, 33, 6, 10, 23, 22, 40, 27, 72};
    for (int e = 0; e < 11; e++) begin
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      src_sel[3*slot[e] +: 3] = code[e][2:0];
      do_reset();
      follow(slot[e], pin[e]);
    end
    // a left edge slot has no high pin: that code yields a quiet line
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    src_sel[3*8 +: 3] = 3'h1;
    do_reset();
    settle(8);
    repeat (6) begin
      @(posedge sys_clk_i);
      #1;
      cmp(ll[0], 1'b0, "absent candidate not low");
    end
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    src_sel = {24{SRC_ROUTE}};
    do_reset();
  endtask : t_pin_map

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    src_sel = {24{SRC_ROUTE}};
    sel = '0;
    ena = '1;
    mode = '0;
    do_reset();
    follow(0, 56);
    t_switch();
    t_cross();
    t_buffer();
    t_gated();
    t_mode3();
    t_pin_map();
    summarize();
  end
endmodule : tb
